// file: vac_check.sv
// Virtual address range check, field split and page protection check
`timescale 1ns/1ps
`include "vac_cfg.svh"
// Notes on behaviour
// - Four privilege levels: kernel, executive, supervisor, user
// - Per-page, per-level none, read or read/write
// - Page may be limited to data access only, not to fetch only
// - Every access presents a 64-bit virtual address
// - Implemented width 43, 47, 51 or 55
// - Upper bits must equal top implemented bit
// - Out-of-range address raises access violation
// - Page size 8 to 64 Kbytes
// - Three equal level fields above offset
// - Widths per page size table
// - Page frame number always 32 bits
// - Physical address at most 48 bits
// - Two top physical bits give space type
// - Checking always on, no disable
// - Store needs level write enable, bits 15:12
// - Load or fetch needs level read enable
// - Fetch with execute fault flag faults
module vac_check #(
  parameter int PAGE_KB = `VAC_PAGE_KB_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire vac_pkg::vac_req_t req_i,
  output logic grant_o,
  output logic fault_valid_o,
  output vac_pkg::vac_fault_t fault_o,
  output logic [`VAC_PA_MAX-1:0] phys_addr_o,
  output logic [1:0] space_type_o,
  output logic [12:0] level1_o,
  output logic [12:0] level2_o,
  output logic [12:0] level3_o
);
  // ----------------------------------------
  // Derived widths
  // ----------------------------------------
  // Offset from page size
  localparam int OFS_W = (PAGE_KB == 64) ? `VAC_OFS_64K : (PAGE_KB == 32) ? `VAC_OFS_32K :
                         (PAGE_KB == 16) ? `VAC_OFS_16K : `VAC_OFS_8K;
  localparam int LVL_W = OFS_W - `VAC_ENTRY_SHIFT;
  localparam int implemented_va_width = OFS_W + 3 * LVL_W;
  localparam int PA_W = OFS_W + `VAC_FRAME_BITS;

  logic grant_ff;
  logic fault_valid_ff;
  vac_pkg::vac_fault_t fault_ff;
  logic [`VAC_PA_MAX-1:0] pa_ff;
  logic [1:0] space_ff;
  logic [12:0] lvl_ff [3];

  // ----------------------------------------
  // Combinational checks
  // ----------------------------------------
  logic [63:0] va;
  logic range_ok;
  logic rd_ok;
  logic wr_ok;
  logic exec_flt;
  logic acc_bad;
  logic [`VAC_FRAME_BITS-1:0] page_frame_number;
  logic [`VAC_PA_MAX-1:0] nxt_pa;
  assign va = req_i.vaddr;
  // Upper bits all equal the top implemented bit
  assign range_ok = (va[63:implemented_va_width-1] == '0) ||
                    (va[63:implemented_va_width-1] == '1);
  // Level enables indexed by mode, kernel lowest
  assign rd_ok = req_i.page_table_entry[`VAC_RE_LO + req_i.mode];
  assign wr_ok = req_i.page_table_entry[`VAC_WE_LO + req_i.mode];
  // Data-only limit via execute fault flag: a fetch from a flagged page faults
  assign exec_flt = (req_i.kind == vac_pkg::VAC_FETCH) &&
                    req_i.page_table_entry[`VAC_EXEC_FAULT_BIT];
  // Stores need the read enable too: write without read is left undefined
  assign acc_bad = !range_ok || !rd_ok ||
                   ((req_i.kind == vac_pkg::VAC_STORE) && !wr_ok);
  assign page_frame_number = req_i.page_table_entry[63:`VAC_FRAME_LO];
  // Frame number joined with page offset, zero above
  always_comb begin
    nxt_pa = '0;
    nxt_pa[PA_W-1:0] = {page_frame_number, va[OFS_W-1:0]};
  end

  // ----------------------------------------
  // Result registers; flags load every cycle, the rest on valid requests
  // ----------------------------------------
  // Grant and fault flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grant_ff <= 1'b0;
      fault_valid_ff <= 1'b0;
    end else begin
      grant_ff <= req_valid_i && !acc_bad && !exec_flt;
      fault_valid_ff <= req_valid_i && (acc_bad || exec_flt);
    end
  end

  // Fault details beside the flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_ff <= '0;
    end else if (req_valid_i) begin
      fault_ff.acc_viol <= acc_bad;
      fault_ff.exec_fault <= exec_flt && !acc_bad;
      fault_ff.vaddr <= va;
      fault_ff.kind <= req_i.kind;
    end
  end

  // Physical address, space type and level fields
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_ff <= '0;
      space_ff <= 2'h0;
    end else if (req_valid_i) begin
      pa_ff <= nxt_pa;
      space_ff <= nxt_pa[PA_W-1 -: 2];
    end
  end

  for (genvar g = 0; g < 3; g++) begin : g_lvl
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        lvl_ff[g] <= 13'h0;
      end else if (req_valid_i) begin
        lvl_ff[g] <= 13'(va[OFS_W + (2 - g) * LVL_W +: LVL_W]);
      end
    end
  end

  assign grant_o = grant_ff;
  assign fault_valid_o = fault_valid_ff;
  assign fault_o = fault_ff;
  assign phys_addr_o = pa_ff;
  assign space_type_o = space_ff;
  assign level1_o = lvl_ff[0];
  assign level2_o = lvl_ff[1];
  assign level3_o = lvl_ff[2];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_range_viol: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && !range_ok |=> fault_valid_o && fault_o.acc_viol)
    else $error("out of range address not flagged");
  chk_store_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.kind == vac_pkg::VAC_STORE && !wr_ok |=> fault_o.acc_viol)
    else $error("store without write enable passed");
  chk_read_rd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && !rd_ok |=> !grant_o && fault_valid_o)
    else $error("read without read enable passed");
  chk_exec_flt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && range_ok && rd_ok && exec_flt |=> fault_o.exec_fault)
    else $error("execute fault missing");
  chk_fault_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_valid_o |-> fault_o.vaddr == $past(req_i.vaddr) && fault_o.kind == $past(req_i.kind))
    else $error("fault address mismatch");
  chk_grant_excl: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(grant_o && fault_valid_o))
    else $error("grant and fault together");
  chk_pa_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    grant_o |-> phys_addr_o[PA_W-1:OFS_W] == $past(req_i.page_table_entry[63:32]))
    else $error("frame number not in physical address");
  chk_space_type: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    grant_o |-> space_type_o == $past(req_i.page_table_entry[63:62]))
    else $error("space type bits wrong");

  // ----------------------------------------
  // Reference checks on the request fields
  // ----------------------------------------
  // Address rebuilt from its top implemented bit; kept apart from the range
  // compare so that a wrong bound there cannot hide in the checks too
  logic [63:0] ref_sext;
  always_comb begin
    ref_sext = va;
    for (int b = implemented_va_width; b < 64; b++) begin
      ref_sext[b] = va[implemented_va_width-1];
    end
  end

  // Each request answered once, on the next edge only
  chk_answer_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i |=> grant_o != fault_valid_o)
    else $error("request not answered exactly once");
  chk_idle_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !req_valid_i |=> !grant_o && !fault_valid_o)
    else $error("answer without request");

  // Range decision against the rebuilt address
  chk_sext_bad: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && ref_sext != va |=> fault_valid_o && fault_o.acc_viol)
    else $error("address with mixed upper bits accepted");
  chk_sext_good: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && ref_sext == va && rd_ok && req_i.kind == vac_pkg::VAC_LOAD |=> grant_o)
    else $error("readable in-range load refused");

  // Protection by level and kind
  chk_store_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && ref_sext == va && rd_ok && wr_ok && req_i.kind == vac_pkg::VAC_STORE
    |=> grant_o)
    else $error("writable in-range store refused");
  chk_fetch_rd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.kind == vac_pkg::VAC_FETCH && !rd_ok
    |=> fault_o.acc_viol && !fault_o.exec_fault)
    else $error("fetch without read enable not flagged");
  chk_exec_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_i.kind == vac_pkg::VAC_FETCH &&
    req_i.page_table_entry[`VAC_EXEC_FAULT_BIT] |=> fault_valid_o && !grant_o)
    else $error("fetch from execute-fault page granted");

  // Field split and byte offset carried straight through
  chk_level_split: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i |=> {level1_o[LVL_W-1:0], level2_o[LVL_W-1:0], level3_o[LVL_W-1:0]}
    == $past(va[implemented_va_width-1:OFS_W])
    && (level1_o >> LVL_W) == 13'h0 && ((level2_o | level3_o) >> LVL_W) == 13'h0)
    else $error("level fields do not tile the address");
  chk_pa_offset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i |=> phys_addr_o[OFS_W-1:0] == $past(va[OFS_W-1:0])
    && (phys_addr_o >> PA_W) == '0)
    else $error("offset or unused physical bits wrong");
endmodule

// file: vac_cfg.svh
// Constants for the virtual address check block
`ifndef VAC_CFG_SVH
`define VAC_CFG_SVH
`define VAC_VA_BITS 64
`define VAC_FRAME_BITS 32
`define VAC_FRAME_LO 32
`define VAC_PA_MAX 48
`define VAC_PAGE_KB_DEF 8
`define VAC_MIN_VA 43
`define VAC_OFS_8K 13
`define VAC_OFS_16K 14
`define VAC_OFS_32K 15
`define VAC_OFS_64K 16
`define VAC_ENTRY_SHIFT 3
`define VAC_WE_LO 12
`define VAC_RE_LO 8
`define VAC_EXEC_FAULT_BIT 3
`endif

// file: vac_pkg.sv
// Types for the virtual address check block
package vac_pkg;
  // Privilege levels, most to least privileged
  typedef enum logic [1:0] {
    VAC_KERNEL = 2'b00,
    VAC_EXEC = 2'b01,
    VAC_SUPER = 2'b10,
    VAC_USER = 2'b11
  } vac_mode_t;
  // Kind of access
  typedef enum logic [1:0] {
    VAC_LOAD = 2'b00,
    VAC_STORE = 2'b01,
    VAC_FETCH = 2'b10
  } vac_kind_t;
  // Request from fetch or load/store logic
  typedef struct packed {
    logic [63:0] vaddr;
    vac_mode_t mode;
    vac_kind_t kind;
    logic [63:0] page_table_entry;
  } vac_req_t;
  // Fault report
  typedef struct packed {
    logic acc_viol;
    logic exec_fault;
    logic [63:0] vaddr;
    vac_kind_t kind;
  } vac_fault_t;
endpackage

// file: vac_req_model.sv
// Model of the fetch and load/store logic that issues check requests
`timescale 1ns/1ps
module vac_req_model (
  input wire logic clk_i,
  output logic req_valid_o,
  output vac_pkg::vac_req_t req_o
);
  initial begin
    req_valid_o = 1'b0;
    req_o = '0;
  end
  // One request a call, full 64-bit address
  task automatic send(input vac_pkg::vac_req_t r);
    req_o = r;
    req_valid_o = 1'b1;
    @(posedge clk_i);
    #1;
    req_valid_o = 1'b0;
    req_o = ~r; // Stale lines do not keep old value
  endtask
endmodule

// file: virtual_address_check_tb_top.sv
// Self-checking bench for the virtual address check block
`timescale 1ns/1ps
module virtual_address_check_tb_top;
  typedef struct {
    logic [63:0] va;
    vac_pkg::vac_mode_t md;
    vac_pkg::vac_kind_t kd;
    logic [15:0] prot;
    logic [2:0] exp;
  } vac_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i;
  vac_pkg::vac_req_t req_i;
  logic grant_o, fault_valid_o;
  vac_pkg::vac_fault_t fault_o;
  logic [47:0] phys_addr_o;
  logic [1:0] space_type_o;
  logic [12:0] level1_o, level2_o, level3_o;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] frame = 32'hc000_1234;
  logic [63:0] big_va = 64'h0000_4000_0012_3456;
  logic grant_big, fault_valid_big;
  vac_pkg::vac_fault_t fault_big;
  logic [47:0] phys_big;
  logic [1:0] space_big;
  logic [12:0] lvl1_big, lvl2_big, lvl3_big;
  vac_row_t rows[8];
  vac_check #(.PAGE_KB(8)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .grant_o(grant_o), .fault_valid_o(fault_valid_o), .fault_o(fault_o),
    .phys_addr_o(phys_addr_o), .space_type_o(space_type_o), .level1_o(level1_o),
    .level2_o(level2_o), .level3_o(level3_o));
  vac_req_model u_src (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_o(req_i));
  // Largest page size, widest valid range and fields
  vac_check #(.PAGE_KB(64)) u_dut_big (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .grant_o(grant_big),
    .fault_valid_o(fault_valid_big), .fault_o(fault_big), .phys_addr_o(phys_big),
    .space_type_o(space_big), .level1_o(lvl1_big), .level2_o(lvl2_big),
    .level3_o(lvl3_big));
  // Clock, 100 ns period
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Send one row, compare flags and fault report, and the map outputs when granted
  task automatic run_row(input vac_row_t r);
    u_src.send('{r.va, r.md, r.kd, {frame, 16'h0000, r.prot}});
    check("grant", r.exp[2], grant_o);
    check("refuse", !r.exp[2], fault_valid_o);
    check("fault", {r.exp[1:0], r.va, r.kd}, fault_o);
    if (r.exp[2]) check("map", {3'h0, frame, r.va[12:0], frame[31:30], 3'h0, r.va[42:33],
      3'h0, r.va[32:23], 3'h0, r.va[22:13]}, {phys_addr_o, space_type_o, level1_o,
      level2_o, level3_o});
    @(posedge clk_i);
    #1;
    check("drop", 2'b00, {grant_o, fault_valid_o});
  endtask
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    // Rows with unlike protection lie in separate 64-Kbyte regions
    rows[0] = '{64'h0000_03ff_ffff_e123, vac_pkg::VAC_KERNEL, vac_pkg::VAC_LOAD, 16'h0108, 3'h4};
    rows[1] = '{64'hffff_fc00_0000_0000, vac_pkg::VAC_USER, vac_pkg::VAC_STORE, 16'h8800, 3'h4};
    rows[2] = '{64'h0000_0000_0001_0000, vac_pkg::VAC_EXEC, vac_pkg::VAC_STORE, 16'h0200, 3'h2};
    rows[3] = '{64'h10, vac_pkg::VAC_SUPER, vac_pkg::VAC_FETCH, 16'hfb00, 3'h2};
    rows[4] = '{64'h0000_0000_0002_0020, vac_pkg::VAC_USER, vac_pkg::VAC_FETCH, 16'h0808, 3'h1};
    rows[5] = '{64'h0000_0400_0000_0000, vac_pkg::VAC_KERNEL, vac_pkg::VAC_LOAD, 16'hff00, 3'h2};
    rows[6] = '{64'hffff_fbff_ffff_ffff, vac_pkg::VAC_KERNEL, vac_pkg::VAC_LOAD, 16'hff00, 3'h2};
    rows[7] = '{64'h0000_0000_0003_0030, vac_pkg::VAC_KERNEL, vac_pkg::VAC_FETCH, 16'hfe08, 3'h2};
    repeat (5) @(posedge clk_i);
    check("rst", 2'b00, {grant_o, fault_valid_o});
    #1 rst_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    foreach (rows[i]) run_row(rows[i]);
    // Reset in mid-run clears the answer, then work resumes
    rst_n_i = 1'b0;
    #10;
    check("rst2", 128'h0, {grant_o, fault_valid_o, phys_addr_o, space_type_o, level1_o,
      level2_o, level3_o});
    check("rst2_fault", 128'h0, fault_o);
    @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    run_row(rows[1]);
    // Same address is out of range for small pages, in range for large ones
    u_src.send('{big_va, vac_pkg::VAC_KERNEL, vac_pkg::VAC_LOAD, {frame, 32'h0000_0100}});
    check("narrow", 2'b11, {fault_valid_o, fault_o.acc_viol});
    check("big_map", {2'b10, frame, big_va[15:0], frame[31:30], big_va[54:42],
      big_va[41:29], big_va[28:16]}, {grant_big, fault_valid_big, phys_big, space_big,
      lvl1_big, lvl2_big, lvl3_big});
    @(posedge clk_i);
    #1;
    u_src.send('{64'h0080_0000_0000_0000, vac_pkg::VAC_KERNEL, vac_pkg::VAC_LOAD,
      {frame, 32'h0000_0100}});
    check("big_range", 2'b11, {fault_valid_big, fault_big.acc_viol});
    report_and_stop();
  end
endmodule
